// ===== inc/clk_mode_pkg.sv
// Constants, carriers and state layout for the clock mode control block
package clk_mode_pkg;

  localparam logic [15:0] CFG_ADDR = 16'h0058;
  localparam logic [15:0] CFG_RESET = 16'hf003;

  localparam int MUL_HI = 15;
  localparam int MUL_LO = 12;
  localparam int FRAC_BIT = 11;
  localparam int CNT_HI = 10;
  localparam int CNT_LO = 3;
  localparam int FORCE_BIT = 2;
  localparam int MODE_BIT = 1;
  localparam int IND_BIT = 0;

  localparam logic [3:0] MUL_BYPASS = 4'hf;
  localparam int PRESCALE_DIV = 16;
  localparam logic [3:0] PRESC_LAST = 4'(PRESCALE_DIV - 1);

  localparam logic [3:0] NUM_ONE = 4'h1;
  localparam logic [2:0] DEN_ONE = 3'h1;
  localparam logic [2:0] DEN_HALF = 3'h2;
  localparam logic [2:0] DEN_QUARTER = 3'h4;

  typedef enum logic [1:0] {
    GEN_DIV = 2'b00,
    GEN_LOCK = 2'b01,
    GEN_PLL = 2'b10
  } gen_state_t;

  typedef enum logic [1:0] {
    SRC_DIV = 2'b00,
    SRC_REF = 2'b01,
    SRC_VCO = 2'b10
  } src_t;

  typedef struct packed {
    logic [3:0] num;
    logic [2:0] den;
  } ratio_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic subsys_b;
  } bus_req_t;

  typedef struct packed {
    gen_state_t st;
    logic [15:1] cfg;
    logic [7:0] lock_cnt;
    logic [3:0] presc;
    logic [1:0] ref_sync;
    logic [1:0] vco_sync;
    logic ref_prev;
    logic div_phase;
    logic div_clk;
    src_t src;
    logic mclk;
    logic ind;
    logic [15:0] rdata;
    logic rvalid;
    logic vco_en;
    logic lock_busy;
    ratio_t ratio;
  } state_t;

  localparam state_t STATE_RESET = '{
    st: GEN_PLL, cfg: CFG_RESET[15:1], lock_cnt: 8'h00, presc: 4'h0,
    ref_sync: 2'h0, vco_sync: 2'h0, ref_prev: 1'b0, div_phase: 1'b0,
    div_clk: 1'b0, src: SRC_REF, mclk: 1'b0, ind: 1'b1, rdata: 16'h0000,
    rvalid: 1'b0, vco_en: 1'b1, lock_busy: 1'b0,
    ratio: '{num: NUM_ONE, den: DEN_ONE}
  };

endpackage

// ===== hdl/pll_clock_mode_control.sv
// Clock mode register, lock timer and glitch-free master clock selection
//
// What this block does
// - Divider mode halves the reference clock, or quarters it at multiplier 15
// - Reset leaves bypass: output equals reference
// - Only subsystem A reaches the mode register
// - One 16-bit read/write register at 0058h
// - Fields: multiplier, fraction, count, force, mode, status
// - Fraction bit picks integer or non-integer factor
// - Lock timer counts down every 16 references
// - Leaving divider mode, no PLL clocking before lock timer expires
// - Mode bit requests PLL or divider mode
// - Status bit reads 1 only when not divider-clocked: from the PLL or, in bypass, from the reference
// - Oscillator off only when force and mode clear
// - Divider mode lets oscillator shut down fully
// - Divider ratio is half, quarter for fifteen
// - PLL ratio table: integer, bypass, halves, quarters
// - Fraction and count fields ignored while in divider mode
// - Timer loads on divider-to-PLL change, 0..255
// - Divider clocking continues until timer hits zero
`timescale 1ns/10ps

module pll_clock_mode_control (
  input wire logic sys_clk_i, // 100 MHz system clock
  input wire logic reset_n_i, // Asynchronous reset, active low
  input wire logic clk_en_i, // Freezes all state while low
  input wire logic reference_clock_in_i, // External reference clock pin
  input wire logic vco_clock_i, // Oscillator output of the analog PLL
  input clk_mode_pkg::bus_req_t bus_i, // Data bus access, one per cycle
  output logic [15:0] rdata_o, // Read data, valid with rvalid_o
  output logic rvalid_o, // One-cycle pulse after a read
  output logic master_clock_out_o, // Selected device master clock
  output logic mode_indication_o, // 1 while clocked from the PLL side
  output logic vco_enable_o, // Runs the analog oscillator
  output logic lock_busy_o, // Lock timer is counting
  output clk_mode_pkg::ratio_t ratio_o // Requested ratio num/den
);
  import clk_mode_pkg::*;

  state_t s_reg;
  state_t s_next;
  logic ref_edge;
  logic div4;
  logic bypass;
  logic hit;
  src_t want;

  // Level of a clock source as seen through its synchroniser
  function automatic logic src_level(input src_t src, input state_t s);
    logic lvl;
    lvl = s.div_clk;
    if (src == SRC_REF) begin
      lvl = s.ref_sync[1];
    end else if (src == SRC_VCO) begin
      lvl = s.vco_sync[1];
    end
    return lvl;
  endfunction

  // Ratio from mode bit, fraction bit and multiplier field
  function automatic ratio_t calc_ratio(input logic [15:1] cfg);
    ratio_t r;
    logic [3:0] m;
    m = cfg[MUL_HI:MUL_LO];
    r.num = m + NUM_ONE;
    r.den = DEN_ONE;
    if (!cfg[MODE_BIT]) begin
      r.num = NUM_ONE;
      r.den = (m == MUL_BYPASS) ? DEN_QUARTER : DEN_HALF;
    end else if (!cfg[FRAC_BIT]) begin
      if (m == MUL_BYPASS) begin
        r.num = NUM_ONE;
      end
    end else if (m[0]) begin
      r.num = m;
      r.den = DEN_QUARTER;
    end else begin
      r.den = DEN_HALF;
    end
    return r;
  endfunction

  always_comb begin
    s_next = s_reg;
    ref_edge = s_reg.ref_sync[1] & ~s_reg.ref_prev;
    div4 = !s_reg.cfg[MODE_BIT] && (s_reg.cfg[MUL_HI:MUL_LO] == MUL_BYPASS);
    bypass = !s_reg.cfg[FRAC_BIT] && (s_reg.cfg[MUL_HI:MUL_LO] == MUL_BYPASS);
    hit = (bus_i.addr == CFG_ADDR) && !bus_i.subsys_b;

    // Pins are sampled twice before anything looks at them
    s_next.ref_sync = {s_reg.ref_sync[0], reference_clock_in_i};
    s_next.vco_sync = {s_reg.vco_sync[0], vco_clock_i};
    s_next.ref_prev = s_reg.ref_sync[1];

    // Divider runs always, so a return to divider mode needs no restart
    if (ref_edge) begin
      s_next.div_phase = ~s_reg.div_phase;
      if (!div4 || s_reg.div_phase) begin
        s_next.div_clk = ~s_reg.div_clk;
      end
    end

    // Register access; the status bit is never written
    s_next.rvalid = 1'b0;
    s_next.rdata = 16'h0000;
    if (bus_i.wr && hit) begin
      s_next.cfg = bus_i.wdata[15:1];
    end
    if (bus_i.rd) begin
      s_next.rvalid = 1'b1;
      if (hit) begin
        // Fields read back as stored; in divider mode only multiplier and force are used
        s_next.rdata = {s_reg.cfg, s_reg.ind};
      end
    end

    // Lock timer and clock mode sequencing
    unique case (s_reg.st)
      GEN_DIV: begin
        // Start only once the divider drives the clock, so locking never runs PLL-clocked
        if (s_reg.cfg[MODE_BIT] && s_reg.src == SRC_DIV) begin
          s_next.st = GEN_LOCK;
          s_next.lock_cnt = s_reg.cfg[CNT_HI:CNT_LO];
          s_next.presc = 4'h0;
        end
      end
      GEN_LOCK: begin
        if (!s_reg.cfg[MODE_BIT]) begin
          s_next.st = GEN_DIV;
        end else if (s_reg.lock_cnt == 8'h00) begin
          s_next.st = GEN_PLL;
        end else if (ref_edge) begin
          s_next.presc = s_reg.presc + 4'h1;
          if (s_reg.presc == PRESC_LAST) begin
            s_next.lock_cnt = s_reg.lock_cnt - 8'h01;
          end
        end
      end
      GEN_PLL: begin
        if (!s_reg.cfg[MODE_BIT]) begin
          s_next.st = GEN_DIV;
        end
      end
      default: begin
        s_next.st = GEN_DIV;
      end
    endcase
    s_next.lock_busy = (s_next.st == GEN_LOCK);

    // Divider keeps clocking the device until the PLL side is released
    if (s_reg.st == GEN_PLL) begin
      want = bypass ? SRC_REF : SRC_VCO;
    end else begin
      want = SRC_DIV;
    end

    // Switch only while output and new source are both low, so the
    // switch can stretch a low phase but never cut a pulse short
    if (s_reg.src != want && !s_reg.mclk && !src_level(want, s_reg)) begin
      s_next.src = want;
    end
    s_next.mclk = src_level(s_next.src, s_reg);
    s_next.ind = (s_next.src != SRC_DIV);

    s_next.vco_en = s_next.cfg[FORCE_BIT] | s_next.cfg[MODE_BIT];
    s_next.ratio = calc_ratio(s_next.cfg);
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_reg <= STATE_RESET;
    end else if (clk_en_i) begin
      s_reg <= s_next;
    end
  end

  assign rdata_o = s_reg.rdata;
  assign rvalid_o = s_reg.rvalid;
  assign master_clock_out_o = s_reg.mclk;
  assign mode_indication_o = s_reg.ind;
  assign vco_enable_o = s_reg.vco_en;
  assign lock_busy_o = s_reg.lock_busy;
  assign ratio_o = s_reg.ratio;

  // Checks on the block's own behaviour
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);

  sequence lock_start;
    clk_en_i && s_reg.st == GEN_DIV && s_reg.cfg[MODE_BIT] && s_reg.src == SRC_DIV;
  endsequence

  sequence lock_loaded;
    s_reg.st == GEN_LOCK && s_reg.lock_cnt == $past(s_reg.cfg[CNT_HI:CNT_LO]);
  endsequence

  sequence lock_wrap;
    clk_en_i && s_reg.st == GEN_LOCK && s_reg.cfg[MODE_BIT]
      && s_reg.lock_cnt != 8'h00 && ref_edge && s_reg.presc == PRESC_LAST;
  endsequence

  sequence lock_idle;
    clk_en_i && s_reg.st == GEN_LOCK && s_reg.cfg[MODE_BIT]
      && s_reg.lock_cnt != 8'h00 && !(ref_edge && s_reg.presc == PRESC_LAST);
  endsequence

  a_lock_load: assert property (
    lock_start |=> lock_loaded
  ) else $error("lock timer not loaded on change to PLL mode");

  a_lock_step: assert property (
    lock_wrap |=> s_reg.lock_cnt == $past(s_reg.lock_cnt) - 8'h01
  ) else $error("lock timer missed its decrement");

  a_lock_hold: assert property (
    lock_idle |=> s_reg.lock_cnt == $past(s_reg.lock_cnt) && s_reg.st == GEN_LOCK
  ) else $error("lock timer moved between prescaler wraps");

  a_lock_done: assert property (
    clk_en_i && s_reg.st == GEN_LOCK && s_reg.cfg[MODE_BIT] && s_reg.lock_cnt == 8'h00
      |=> s_reg.st == GEN_PLL
  ) else $error("PLL mode not entered at timer zero");

  a_pll_gate: assert property (
    $rose(s_reg.src == SRC_VCO) |-> $past(s_reg.st) == GEN_PLL
  ) else $error("PLL clock selected before lock time");

  a_no_runt: assert property (
    s_reg.src != $past(s_reg.src) |-> !master_clock_out_o && !$past(master_clock_out_o)
  ) else $error("clock source changed outside a low phase");

  a_status_src: assert property (
    mode_indication_o == (s_reg.src != SRC_DIV) && (!mode_indication_o || !lock_busy_o
      || s_reg.src != SRC_VCO)
  ) else $error("mode indication disagrees with clock source");

  a_vco_off: assert property (
    clk_en_i && s_reg.st == GEN_LOCK && s_reg.cfg[MODE_BIT]
      |-> vco_enable_o ##1 !clk_en_i || vco_enable_o
      || !s_reg.cfg[MODE_BIT]
  ) else $error("oscillator stopped while locking");

  a_vco_rule: assert property (
    vco_enable_o == (s_reg.cfg[FORCE_BIT] || s_reg.cfg[MODE_BIT])
  ) else $error("oscillator enable disagrees with force and mode bits");

  a_b_blocked: assert property (
    clk_en_i && bus_i.subsys_b && (bus_i.wr || bus_i.rd)
      |=> s_reg.cfg == $past(s_reg.cfg) && rdata_o == 16'h0000
  ) else $error("second subsystem reached the mode register");

  a_cfg_write: assert property (
    clk_en_i && bus_i.wr && !bus_i.subsys_b && bus_i.addr == CFG_ADDR
      |=> s_reg.cfg == $past(bus_i.wdata[15:1])
  ) else $error("mode register write lost");

  a_ratio_div: assert property (
    !s_reg.cfg[MODE_BIT] |-> ratio_o.num == NUM_ONE && ratio_o.den ==
      ((s_reg.cfg[MUL_HI:MUL_LO] == MUL_BYPASS) ? DEN_QUARTER : DEN_HALF)
  ) else $error("divider ratio wrong");

  a_ratio_odd: assert property (
    s_reg.cfg[MODE_BIT] && s_reg.cfg[FRAC_BIT] && s_reg.cfg[MUL_LO]
      |-> ratio_o.num == s_reg.cfg[MUL_HI:MUL_LO] && ratio_o.den == DEN_QUARTER
  ) else $error("odd fractional ratio wrong");

  a_reset_bypass: assert property (
    $rose(reset_n_i) |-> s_reg.src == SRC_REF && mode_indication_o && vco_enable_o
  ) else $error("reset did not leave bypass clocking");

  a_presc_clear: assert property (
    lock_start |=> s_reg.presc == 4'h0 && lock_busy_o
  ) else $error("prescaler not cleared when locking starts");

  a_lock_gate: assert property (
    lock_busy_o |-> !mode_indication_o && s_reg.src == SRC_DIV
  ) else $error("lock timer running while not divider-clocked");

  a_read_strobe: assert property (
    clk_en_i |=> rvalid_o == $past(bus_i.rd) && (rvalid_o || rdata_o == 16'h0000)
  ) else $error("read answer pulse does not follow the read strobe");

  a_read_data: assert property (
    clk_en_i && bus_i.rd && !bus_i.subsys_b && bus_i.addr == CFG_ADDR
      |=> rdata_o == {$past(s_reg.cfg), $past(mode_indication_o)}
  ) else $error("mode register read back wrong");

  a_div_half: assert property (
    clk_en_i && ref_edge && !div4 |=> s_reg.div_clk != $past(s_reg.div_clk)
  ) else $error("divider missed a reference edge");

  a_div_quarter: assert property (
    clk_en_i && ref_edge && div4
      |=> s_reg.div_clk == ($past(s_reg.div_clk) ^ $past(s_reg.div_phase))
  ) else $error("quarter divider toggled on the wrong edge");

  a_ratio_int: assert property (
    s_reg.cfg[MODE_BIT] && !s_reg.cfg[FRAC_BIT] |-> ratio_o.den == DEN_ONE
      && ratio_o.num == ((s_reg.cfg[MUL_HI:MUL_LO] == MUL_BYPASS) ? NUM_ONE
      : s_reg.cfg[MUL_HI:MUL_LO] + NUM_ONE)
  ) else $error("integer ratio wrong");

  a_ratio_even: assert property (
    s_reg.cfg[MODE_BIT] && s_reg.cfg[FRAC_BIT] && !s_reg.cfg[MUL_LO]
      |-> ratio_o.num == s_reg.cfg[MUL_HI:MUL_LO] + NUM_ONE && ratio_o.den == DEN_HALF
  ) else $error("even fractional ratio wrong");

endmodule

// ===== verification/tb_top.sv
// Self-checking bench for the clock mode control block
`timescale 1ns/10ps
module tb_top;
  import clk_mode_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic ref_clk = 1'b0;
  logic vco_clk = 1'b0;
  logic clk_en = 1'b1;
  logic [2:0] ref_div = 3'h0;
  logic [1:0] vco_div = 2'h0;
  bus_req_t bus = '0;
  logic [15:0] rdata;
  logic rvalid, mclk, ind, vco_en, busy;
  ratio_t ratio;
  int bad_count = 0;
  int n_compared = 0;

  pll_clock_mode_control u_dut (
    .sys_clk_i(sys_clk),
    .reset_n_i(reset_n),
    .clk_en_i(clk_en),
    .reference_clock_in_i(ref_clk),
    .vco_clock_i(vco_clk),
    .bus_i(bus),
    .rdata_o(rdata),
    .rvalid_o(rvalid),
    .master_clock_out_o(mclk),
    .mode_indication_o(ind),
    .vco_enable_o(vco_en),
    .lock_busy_o(busy),
    .ratio_o(ratio)
  );

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  // Reference at clk/8 and oscillator at clk/4 keep both under the synchroniser limit
  always @(posedge sys_clk) begin
    ref_div <= ref_div + 3'h1;
    vco_div <= vco_div + 2'h1;
    ref_clk <= ref_div[2];
    vco_clk <= vco_div[1];
  end

  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic sb);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0, subsys_b: sb};
    @(posedge sys_clk);
    bus <= '0;
  endtask

  task automatic rd(input logic [15:0] a, input logic sb, output logic [15:0] d);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1, subsys_b: sb};
    @(posedge sys_clk);
    bus <= '0;
    #1;
    check("rvalid", 32'(rvalid), 32'h1);
    d = rdata;
  endtask

  // Counts master clock rising edges over 640 cycles
  task automatic t_clk(input int exp);
    int n;
    logic p;
    n = 0;
    p = mclk;
    repeat (640) begin
      @(posedge sys_clk);
      #1;
      if (mclk && !p) n++;
      p = mclk;
    end
    check("mclk_rises", 32'(n >= exp - 1 && n <= exp + 1), 32'h1);
  endtask

  task automatic t_reset;
    logic [15:0] d;
    rd(CFG_ADDR, 1'b0, d);
    check("cfg_reset", 32'(d), 32'hf003);
    check("ind_reset", 32'(ind), 32'h1);
    check("ratio_reset", 32'(ratio), 32'({4'h1, 3'h1}));
    t_clk(80);
  endtask

  task automatic t_access;
    logic [15:0] d;
    wr(CFG_ADDR, 16'h0006, 1'b1);
    rd(CFG_ADDR, 1'b0, d);
    check("cfg_after_b", 32'(d), 32'hf003);
    rd(CFG_ADDR, 1'b1, d);
    check("rdata_b", 32'(d), 32'h0);
    rd(16'h0059, 1'b0, d);
    check("rdata_unmapped", 32'(d), 32'h0);
    // Bit 0 written low must still read the live status
    wr(CFG_ADDR, 16'ha5f6, 1'b0);
    rd(CFG_ADDR, 1'b0, d);
    check("cfg_fields", 32'(d), 32'ha5f7);
  endtask

  // A write while the clock enable is low must not land
  task automatic t_freeze;
    logic [15:0] d;
    @(posedge sys_clk);
    clk_en <= 1'b0;
    wr(CFG_ADDR, 16'h0004, 1'b0);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    rd(CFG_ADDR, 1'b0, d);
    check("cfg_frozen", 32'(d), 32'ha5f7);
  endtask

  // Every multiplier, fraction, mode and force combination
  task automatic t_ratio;
    logic [3:0] m, en;
    logic [2:0] ed;
    for (int i = 0; i < 128; i++) begin
      m = i[3:0];
      wr(CFG_ADDR, {m, i[4], 8'h00, i[6], i[5], 1'b0}, 1'b0);
      repeat (2) @(posedge sys_clk);
      #1;
      if (!i[5]) begin
        en = 4'h1;
        ed = (m == 4'hf) ? 3'h4 : 3'h2;
      end else if (!i[4]) begin
        en = (m == 4'hf) ? 4'h1 : m + 4'h1;
        ed = 3'h1;
      end else begin
        en = m[0] ? m : m + 4'h1;
        ed = m[0] ? 3'h4 : 3'h2;
      end
      check("ratio_num", 32'(ratio.num), 32'(en));
      check("ratio_den", 32'(ratio.den), 32'(ed));
      check("vco_en", 32'(vco_en), 32'(i[6] | i[5]));
    end
  endtask

  task automatic t_lock(input logic [7:0] cnt, input int lo, input int hi);
    logic [15:0] d;
    int n;
    int k;
    wr(CFG_ADDR, 16'h0000, 1'b0);
    k = 0;
    while (ind !== 1'b0 && k < 50) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    rd(CFG_ADDR, 1'b0, d);
    check("status_div", 32'(d[0]), 32'h0);
    t_clk(40);
    wr(CFG_ADDR, 16'hf000, 1'b0);
    t_clk(20);
    wr(CFG_ADDR, {4'h0, 1'b0, cnt, 1'b0, 1'b1, 1'b0}, 1'b0);
    k = 0;
    while (busy !== 1'b1 && k < 8) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    n = 0;
    while (busy === 1'b1 && n < 40000) begin
      if (ind !== 1'b0) check("ind_locking", 32'(ind), 32'h0);
      @(posedge sys_clk);
      #1;
      n++;
    end
    check("lock_cycles", 32'(n >= lo && n <= hi), 32'h1);
    k = 0;
    while (ind !== 1'b1 && k < 20) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    check("ind_pll", 32'(ind), 32'h1);
    // Locked at multiplier 0, so the master clock now follows the oscillator
    t_clk(160);
  endtask

  // Reset in mid-run must bring back bypass clocking and the reset value
  task automatic t_rerun;
    logic [15:0] d;
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(CFG_ADDR, 1'b0, d);
    check("cfg_rerun", 32'(d), 32'hf003);
    t_clk(80);
  endtask

  task automatic end_of_test;
    if (bad_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #600000;
    bad_count++;
    end_of_test();
  end

  initial begin
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_reset();
    t_access();
    t_freeze();
    t_ratio();
    t_lock(8'h00, 1, 2);
    t_lock(8'h02, 244, 264);
    t_lock(8'hff, 32628, 32648);
    t_rerun();
    end_of_test();
  end
endmodule
